// File: common/fpcvt_pkg.sv
// Constants of the floating point format conversion unit
// ****************************************************************
// What this block does
// - Decode convert_to_long, source single or double
// - Convert to long, current rounding, write result
// - Infinity, NaN or out-of-range sets invalid
// - Invalid with enable: no write, trap now
// - Legacy NaN encoding: default largest positive long
// - New NaN encoding: default depends on input
// - Long conversion defined only in 64-bit mode
// - Pack two singles, first source upper half
// - Data moves leave cause and flags untouched
// - Extract low half as single
// - Extract high half as single
// - Decode convert_to_single, current rounding mode
// - Single from double, word or long
// - Unusable unit or bad encoding raises exception
// - Record invalid, unimplemented, inexact in status
// - Release 6 core rejects paired moves
// ****************************************************************
package fpcvt_pkg;
   // Instruction encoding
   localparam logic [5:0] OP_FP_COPROCESSOR_OPCODE     = 6'h11;
   localparam logic [5:0] FN_CONVERT_TO_LONG    = 6'h25;
   localparam logic [5:0] FN_CONVERT_TO_SINGLE    = 6'h20;
   localparam logic [5:0] FN_CVT_PS   = 6'h26;
   localparam logic [5:0] FN_CVT_SPL  = 6'h28;
   localparam logic [4:0] FMT_S       = 5'h10;
   localparam logic [4:0] FMT_D       = 5'h11;
   localparam logic [4:0] FMT_W       = 5'h14;
   localparam logic [4:0] FMT_L       = 5'h15;
   localparam logic [4:0] FMT_PS      = 5'h16;
   // Rounding modes and single source kinds
   localparam logic [1:0] RM_NEAR     = 2'h0;
   localparam logic [1:0] RM_ZERO     = 2'h1;
   localparam logic [1:0] RM_PLUS     = 2'h2;
   localparam logic [1:0] RM_MINUS    = 2'h3;
   localparam logic [1:0] SRC_DBL     = 2'h0;
   localparam logic [1:0] SRC_WORD    = 2'h1;
   localparam logic [1:0] SRC_LONG    = 2'h2;
   // Register offsets
   localparam logic [7:0] ADDR_FP_CONTROL_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_ISTAT  = 8'h04;
   localparam logic [7:0] ADDR_IMASK  = 8'h08;
   localparam logic [7:0] ADDR_NONE   = 8'hFF;
   // Control/status field positions
   localparam int RM_LSB    = 0;
   localparam int FLAGS_LSB = 2;
   localparam int EN_LSB    = 7;
   localparam int CAUSE_LSB = 12;
   localparam int NAN_BIT   = 18;
   localparam int C_INEXACT = 0;
   localparam int C_UNDER   = 1;
   localparam int C_OVER    = 2;
   localparam int C_INVALID = 4;
   localparam int C_UNIMPL  = 5;
   // Interrupt status bits
   localparam int IRQ_INVALID = 0;
   localparam int IRQ_FPE     = 1;
   localparam int IRQ_RI      = 2;
   localparam int IRQ_CPU     = 3;
   // Reset values
   localparam logic [31:0] FP_CONTROL_STATUS_RESET  = 32'h0000_0000;
   localparam logic [3:0]  IMASK_RESET = 4'h0;
   // Bus and numeric constants
   localparam logic [2:0]  SIZE_WORD   = 3'h2;
   localparam logic        RESP_OKAY   = 1'b0;
   localparam logic [63:0] LONG_MAX    = 64'h7FFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] LONG_MIN    = 64'h8000_0000_0000_0000;
   localparam logic [31:0] QNAN_OLD    = 32'h7FBF_FFFF;
   localparam logic [31:0] QNAN_2008   = 32'h7FC0_0000;
   localparam logic [30:0] SINGLE_MAX  = 31'h7F7F_FFFF;
   localparam logic signed [12:0] BIAS_S = 13'sd127;
   localparam logic signed [12:0] BIAS_D = 13'sd1023;
endpackage : fpcvt_pkg

// File: rtl/fp_format_conversion_unit.sv
// Floating point format conversion unit with AHB-Lite status registers
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
module fp_format_conversion_unit
   import fpcvt_pkg::*;
#(
   parameter bit RELEASE6 = 1'b0
)
(
   // Clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        SYS_RST_I,
   // AHB-Lite slave
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   // Instruction issue
   input  wire logic        INSTR_VALID_I,
   input  wire logic [31:0] INSTR_I,
   input  wire logic [63:0] FS_VALUE_I,
   input  wire logic [63:0] FT_VALUE_I,
   input  wire logic        FPU_USABLE_I,
   input  wire logic        FR_MODE_I,
   // Completion
   output logic             DONE_O,
   output logic             WRITE_O,
   output logic      [4:0]  DEST_O,
   output logic      [63:0] RESULT_O,
   output logic             EXC_COP_UNUSABLE_O,
   output logic             EXC_RESERVED_O,
   output logic             EXC_FP_O,
   // Interrupt
   output logic             IRQ_O
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [1:0]  rmode;
      logic [4:0]  flags;
      logic [4:0]  enables;
      logic [5:0]  cause;
      logic        nan_encoding_select;
      logic [3:0]  istat;
      logic [3:0]  imask;
      logic        ph_wr;
      logic [7:0]  ph_addr;
      logic [31:0] rdata;
      logic        rdy;
      logic        done;
      logic        wr;
      logic [4:0]  dest;
      logic [63:0] result;
      logic        cpu;
      logic        ri;
      logic        fpe;
      logic        irq;
   } state_type;

   state_type   st_r;
   state_type   st_nxt;

   logic [5:0]  opc;
   logic [4:0]  fmt;
   logic [4:0]  ft;
   logic [4:0]  fd;
   logic [5:0]  fn;
   logic        op_l;
   logic        op_s;
   logic        op_pk;
   logic        op_lo;
   logic        op_hi;
   logic        mine;
   logic        legal;
   logic        unimpl;
   logic [1:0]  s_sel;
   logic [63:0] l_val;
   logic        l_inv;
   logic        l_inx;
   logic        l_nan;
   logic        l_neg;
   logic [31:0] s_val;
   logic        s_inv;
   logic        s_ovf;
   logic        s_unf;
   logic        s_inx;

   // ****************************************************************
   // Decode
   // ****************************************************************
   always_comb begin
      opc   = INSTR_I[31:26];
      fmt   = INSTR_I[25:21];
      ft    = INSTR_I[20:16];
      fd    = INSTR_I[10:6];
      fn    = INSTR_I[5:0];
      op_l  = (opc == OP_FP_COPROCESSOR_OPCODE) & (fn == FN_CONVERT_TO_LONG) & (ft == 5'h00) &
              ((fmt == FMT_S) | (fmt == FMT_D));
      op_s  = (opc == OP_FP_COPROCESSOR_OPCODE) & (fn == FN_CONVERT_TO_SINGLE) & (ft == 5'h00) &
              ((fmt == FMT_D) | (fmt == FMT_W) |
               (fmt == FMT_L));
      op_pk = (opc == OP_FP_COPROCESSOR_OPCODE) & (fn == FN_CVT_PS) &
              (fmt == FMT_S) & ~RELEASE6;
      op_lo = (opc == OP_FP_COPROCESSOR_OPCODE) & (fn == FN_CVT_SPL) & (ft == 5'h00) &
              (fmt == FMT_PS) & ~RELEASE6;
      op_hi = (opc == OP_FP_COPROCESSOR_OPCODE) & (fn == FN_CONVERT_TO_SINGLE) & (ft == 5'h00) &
              (fmt == FMT_PS) & ~RELEASE6;
      mine  = (opc == OP_FP_COPROCESSOR_OPCODE) &
              ((fn == FN_CONVERT_TO_LONG) | (fn == FN_CONVERT_TO_SINGLE) |
               (fn == FN_CVT_PS) | (fn == FN_CVT_SPL));
      legal = op_l | op_s | op_pk | op_lo | op_hi;
      unimpl = (op_l | (op_s & (fmt == FMT_L))) & ~FR_MODE_I;
      if (fmt == FMT_W)
         s_sel = SRC_WORD;
      else if (fmt == FMT_L)
         s_sel = SRC_LONG;
      else
         s_sel = SRC_DBL;
   end

   // ****************************************************************
   // Converters
   // ****************************************************************
   fp_to_long u_long (
      .src_i     (FS_VALUE_I),
      .dbl_i     (fmt == FMT_D),
      .rmode_i   (st_r.rmode),
      .value_o   (l_val),
      .invalid_o (l_inv),
      .inexact_o (l_inx),
      .nan_o     (l_nan),
      .neg_o     (l_neg)
   );

   fp_to_single u_single (
      .src_i       (FS_VALUE_I),
      .sel_i       (s_sel),
      .rmode_i     (st_r.rmode),
      .nan_encoding_select_i   (st_r.nan_encoding_select),
      .value_o     (s_val),
      .invalid_o   (s_inv),
      .overflow_o  (s_ovf),
      .underflow_o (s_unf),
      .inexact_o   (s_inx)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic        acc;
      logic [3:0]  ev;
      logic [5:0]  cse;
      logic [63:0] res;
      logic        trap;
      acc  = 1'b0;
      ev   = 4'h0;
      cse  = 6'h00;
      res  = 64'h0;
      trap = 1'b0;
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      st_nxt.wr   = 1'b0;
      st_nxt.cpu  = 1'b0;
      st_nxt.ri   = 1'b0;
      st_nxt.fpe  = 1'b0;
      st_nxt.rdy  = 1'b1;

      // Bus write data phase
      if (st_r.ph_wr) begin
         unique case (st_r.ph_addr)
            ADDR_FP_CONTROL_STATUS: begin
               st_nxt.rmode   = HWDATA_I[RM_LSB +: 2];
               st_nxt.flags   = HWDATA_I[FLAGS_LSB +: 5];
               st_nxt.enables = HWDATA_I[EN_LSB +: 5];
               st_nxt.cause   = HWDATA_I[CAUSE_LSB +: 6];
               st_nxt.nan_encoding_select = HWDATA_I[NAN_BIT];
            end
            ADDR_ISTAT: st_nxt.istat = st_r.istat & ~HWDATA_I[3:0];
            ADDR_IMASK: st_nxt.imask = HWDATA_I[3:0];
            default: ;
         endcase
      end

      // Bus address phase
      acc = HSEL_I & HTRANS_I[1] & HREADY_I;
      st_nxt.ph_wr   = acc & HWRITE_I & (HSIZE_I == SIZE_WORD);
      st_nxt.ph_addr = (HADDR_I[31:8] == 24'h0) ? HADDR_I[7:0] : ADDR_NONE;

      // Instruction execution
      if (INSTR_VALID_I & mine) begin
         st_nxt.done = 1'b1;
         st_nxt.dest = fd;
         if (!FPU_USABLE_I) begin
            st_nxt.cpu   = 1'b1;
            ev[IRQ_CPU]  = 1'b1;
         end else if (!legal) begin
            st_nxt.ri    = 1'b1;
            ev[IRQ_RI]   = 1'b1;
         end else if (op_pk) begin
            res = {FS_VALUE_I[31:0], FT_VALUE_I[31:0]};
         end else if (op_lo) begin
            res = {32'h0, FS_VALUE_I[31:0]};
         end else if (op_hi) begin
            res = {32'h0, FS_VALUE_I[63:32]};
         end else if (unimpl) begin
            cse[C_UNIMPL] = 1'b1;
         end else if (op_l) begin
            cse[C_INVALID] = l_inv;
            cse[C_INEXACT] = l_inx;
            if (!l_inv)
               res = l_val;
            else if (!st_r.nan_encoding_select)
               res = LONG_MAX;
            else if (l_nan)
               res = 64'h0;
            else if (l_neg)
               res = LONG_MIN;
            else
               res = LONG_MAX;
         end else begin
            cse[C_INVALID] = s_inv;
            cse[C_OVER]    = s_ovf;
            cse[C_UNDER]   = s_unf;
            cse[C_INEXACT] = s_inx;
            res = {32'h0, s_val};
         end
         if (FPU_USABLE_I & (op_l | op_s)) begin
            trap = cse[C_UNIMPL] | |(cse[4:0] & st_r.enables);
            st_nxt.cause = cse;
            st_nxt.flags = st_nxt.flags | cse[4:0];
            ev[IRQ_INVALID] = cse[C_INVALID];
         end
         if (FPU_USABLE_I & legal) begin
            st_nxt.fpe   = trap;
            ev[IRQ_FPE]  = trap;
            st_nxt.wr    = ~trap;
            st_nxt.result = res;
         end
      end

      // Sticky events win over a clear in the same cycle
      st_nxt.istat = st_nxt.istat | ev;

      // Read data for the coming data phase
      st_nxt.rdata = 32'h0;
      if (acc & ~HWRITE_I) begin
         unique case (st_nxt.ph_addr)
            ADDR_FP_CONTROL_STATUS: begin
               st_nxt.rdata[RM_LSB +: 2]    = st_nxt.rmode;
               st_nxt.rdata[FLAGS_LSB +: 5] = st_nxt.flags;
               st_nxt.rdata[EN_LSB +: 5]    = st_nxt.enables;
               st_nxt.rdata[CAUSE_LSB +: 6] = st_nxt.cause;
               st_nxt.rdata[NAN_BIT]        = st_nxt.nan_encoding_select;
            end
            ADDR_ISTAT: st_nxt.rdata[3:0] = st_nxt.istat;
            ADDR_IMASK: st_nxt.rdata[3:0] = st_nxt.imask;
            default: ;
         endcase
      end
      st_nxt.irq = |(st_nxt.istat & st_nxt.imask);
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         st_r         <= '0;
         st_r.rmode   <= FP_CONTROL_STATUS_RESET[RM_LSB +: 2];
         st_r.flags   <= FP_CONTROL_STATUS_RESET[FLAGS_LSB +: 5];
         st_r.enables <= FP_CONTROL_STATUS_RESET[EN_LSB +: 5];
         st_r.cause   <= FP_CONTROL_STATUS_RESET[CAUSE_LSB +: 6];
         st_r.nan_encoding_select <= FP_CONTROL_STATUS_RESET[NAN_BIT];
         st_r.imask   <= IMASK_RESET;
         st_r.rdy     <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign HRDATA_O           = st_r.rdata;
   assign HREADYOUT_O        = st_r.rdy;
   assign HRESP_O            = RESP_OKAY;
   assign DONE_O             = st_r.done;
   assign WRITE_O            = st_r.wr;
   assign DEST_O             = st_r.dest;
   assign RESULT_O           = st_r.result;
   assign EXC_COP_UNUSABLE_O = st_r.cpu;
   assign EXC_RESERVED_O     = st_r.ri;
   assign EXC_FP_O           = st_r.fpe;
   assign IRQ_O              = st_r.irq;
endmodule : fp_format_conversion_unit

// File: rtl/fp_to_long.sv
// Single or double to 64-bit long converter with rounding
`timescale 1ns/100ps
module fp_to_long
   import fpcvt_pkg::*;
(
   // Operand
   input  wire logic [63:0] src_i,
   input  wire logic        dbl_i,
   input  wire logic [1:0]  rmode_i,
   // Result
   output logic      [63:0] value_o,
   output logic             invalid_o,
   output logic             inexact_o,
   output logic             nan_o,
   output logic             neg_o
);
   logic               sgn;
   logic               special;
   logic [52:0]        man;
   logic signed [12:0] ue;
   logic [6:0]         rsh;
   logic [116:0]       sh_v;
   logic [64:0]        ip;
   logic [64:0]        mag;
   logic               g;
   logic               s;
   logic               inc;

   always_comb begin
      sgn     = dbl_i ? src_i[63] : src_i[31];
      special = dbl_i ? &src_i[62:52] : &src_i[30:23];
      nan_o   = special & (dbl_i ? |src_i[51:0] : |src_i[22:0]);
      if (dbl_i) begin
         man = {|src_i[62:52], src_i[51:0]};
         ue  = $signed({2'h0, src_i[62:52]}) - BIAS_D;
      end else begin
         man = {|src_i[30:23], src_i[22:0], 29'h0};
         ue  = $signed({5'h0, src_i[30:23]}) - BIAS_S;
      end
      if (ue >= 13'sd52)
         rsh = 7'h00;
      else if (ue < -13'sd64)
         rsh = 7'd116;
      else
         rsh = 7'(13'sd52 - ue);
      sh_v = {man, 64'h0} >> rsh;
      if (ue >= 13'sd52)
         ip = {12'h0, man} << 4'(ue - 13'sd52);
      else
         ip = {12'h0, sh_v[116:64]};
      g = (ue < 13'sd52) & sh_v[63];
      s = (ue < 13'sd52) & |sh_v[62:0];
      unique case (rmode_i)
         RM_NEAR:  inc = g & (s | ip[0]);
         RM_ZERO:  inc = 1'b0;
         RM_PLUS:  inc = (g | s) & ~sgn;
         RM_MINUS: inc = (g | s) & sgn;
      endcase
      mag       = ip + 65'(inc);
      invalid_o = special | (ue > 13'sd63) |
                  (sgn ? (mag > {2'b01, 63'h0}) : |mag[64:63]);
      inexact_o = (g | s) & ~invalid_o;
      value_o   = sgn ? 64'(~mag + 65'h1) : mag[63:0];
      neg_o     = sgn;
   end
endmodule : fp_to_long

// File: rtl/fp_to_single.sv
// Double, word or long to single converter with rounding
`timescale 1ns/100ps
module fp_to_single
   import fpcvt_pkg::*;
(
   // Operand
   input  wire logic [63:0] src_i,
   input  wire logic [1:0]  sel_i,
   input  wire logic [1:0]  rmode_i,
   input  wire logic        nan_encoding_select_i,
   // Result
   output logic      [31:0] value_o,
   output logic             invalid_o,
   output logic             overflow_o,
   output logic             underflow_o,
   output logic             inexact_o
);
   logic               sgn, nan, inf, zero, g, s, inc, ovf, big;
   logic [63:0]        ext, absv, mant;
   logic [6:0]         lz;
   logic signed [13:0] ex, eb;
   logic [7:0]         sh, ef;
   logic [127:0]       v;
   logic [30:0]        sum;

   always_comb begin
      ext  = (sel_i == SRC_WORD) ? {{32{src_i[31]}}, src_i[31:0]} : src_i;
      absv = ext[63] ? (~ext + 64'h1) : ext;
      lz   = 7'h00;
      for (int i = 0; i < 64; i++)
         if (absv[i]) lz = 7'(63 - i);
      if (sel_i == SRC_DBL) begin
         sgn  = src_i[63];
         inf  = &src_i[62:52] & ~|src_i[51:0];
         nan  = &src_i[62:52] & |src_i[51:0];
         zero = ~|src_i[62:0];
         mant = {|src_i[62:52], src_i[51:0], 11'h0};
         ex   = (src_i[62:52] == 11'h000) ? -14'sd1022 :
                $signed({3'h0, src_i[62:52]}) - 14'sd1023;
      end else begin
         sgn  = ext[63];
         inf  = 1'b0;
         nan  = 1'b0;
         zero = (absv == 64'h0);
         mant = absv << lz;
         ex   = 14'sd63 - $signed({7'h0, lz});
      end
      eb = ex + 14'sd127;
      if (eb >= 14'sd1)
         sh = 8'h00;
      else if (eb < -14'sd126)
         sh = 8'd127;
      else
         sh = 8'(14'sd1 - eb);
      ef = (eb >= 14'sd1) ? eb[7:0] : 8'h00;
      v  = {mant, 64'h0} >> sh;
      g  = v[103];
      s  = |v[102:0];
      unique case (rmode_i)
         RM_NEAR:  inc = g & (s | v[104]);
         RM_ZERO:  inc = 1'b0;
         RM_PLUS:  inc = (g | s) & ~sgn;
         RM_MINUS: inc = (g | s) & sgn;
      endcase
      sum = {ef, v[126:104]} + 31'(inc);
      ovf = ~nan & ~inf & ~zero & ((eb > 14'sd254) | &sum[30:23]);
      big = (rmode_i == RM_ZERO) | ((rmode_i == RM_PLUS) & sgn) |
            ((rmode_i == RM_MINUS) & ~sgn);
      if (nan)
         value_o = nan_encoding_select_i ? QNAN_2008 : QNAN_OLD;
      else if (inf)
         value_o = {sgn, 8'hFF, 23'h0};
      else if (zero)
         value_o = {sgn, 31'h0};
      else if (ovf)
         value_o = big ? {sgn, SINGLE_MAX} : {sgn, 8'hFF, 23'h0};
      else
         value_o = {sgn, sum};
      invalid_o   = nan & (src_i[51] ^ nan_encoding_select_i);
      overflow_o  = ovf;
      inexact_o   = (g | s | ovf) & ~(nan | inf | zero);
      underflow_o = (eb < 14'sd1) & (g | s) & ~(nan | inf | zero);
   end
endmodule : fp_to_single

// File: tb/fp_format_conversion_unit_tb_top.sv
// Testbench top for the conversion unit
`timescale 1ns/100ps
module fp_format_conversion_unit_tb_top;
   import fpcvt_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hready, valid, usable, wide, done, wr, ecop, eres, efp, irq;
   logic        hresp;
   logic [31:0] hrdata, instr;
   logic [63:0] src_a, src_b, res;
   logic [4:0]  dest;
   int          num_errors = 0, checks_done = 0;
   logic [63:0] rnd [4] = '{64'h2, 64'h2, 64'h3, 64'h2};
   localparam logic [63:0] PA    = 64'hAAAA_BBBB_1111_2222;
   localparam logic [63:0] PB    = 64'hCCCC_DDDD_3333_4444;
   localparam logic [63:0] PINF  = 64'h7FF0_0000_0000_0000;
   localparam logic [31:0] CVL_D = op(FN_CONVERT_TO_LONG, FMT_D);

   fp_format_conversion_unit i_fp_format_conversion_unit (
      .SYS_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(SIZE_WORD),
      .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .INSTR_VALID_I(valid),
      .INSTR_I(instr), .FS_VALUE_I(src_a), .FT_VALUE_I(src_b),
      .FPU_USABLE_I(usable), .FR_MODE_I(wide), .DONE_O(done), .WRITE_O(wr),
      .DEST_O(dest), .RESULT_O(res), .EXC_COP_UNUSABLE_O(ecop),
      .EXC_RESERVED_O(eres), .EXC_FP_O(efp), .IRQ_O(irq));
   pipe_model i_pipe_model (.clk_i(clk), .valid_o(valid), .instr_o(instr),
      .src_a_o(src_a), .src_b_o(src_b), .usable_o(usable), .wide_o(wide));

   always #4 clk = ~clk;

   function automatic logic [31:0] op(input logic [5:0] fn,
      input logic [4:0] fm, input logic [4:0] mid = 5'h00);
      return {OP_FP_COPROCESSOR_OPCODE, fm, mid, 5'h03, 5'h07, fn};
   endfunction : op
   task automatic chk(input logic [63:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      chk({63'h0, hresp}, {63'h0, RESP_OKAY});
      if (!w) chk({32'h0, hrdata}, {32'h0, d});
   endtask : ahb
   task automatic ex(input logic [31:0] i, input logic [63:0] a,
      input logic [3:0] st, input logic [63:0] r,
      input logic [63:0] b = 64'h0, input logic u = 1'b1, w = 1'b1);
      i_pipe_model.issue(i, a, b, u, w);
      @(posedge clk);
      chk({54'h0, done, wr, ecop, eres, efp, dest}, {54'h0, 1'b1, st, 5'h07});
      if (st[3]) chk(res, r);
   endtask : ex
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   initial begin
      #20000;
      num_errors++;
      $display("unexpected at %0t: run timed out", $time);
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      ahb(1'b0, ADDR_FP_CONTROL_STATUS, FP_CONTROL_STATUS_RESET);
      ahb(1'b0, ADDR_IMASK, 32'h0);
      ahb(1'b1, ADDR_NONE, 32'hFFFF_FFFF);
      ahb(1'b0, ADDR_NONE, 32'h0);
      for (int m = 0; m < 4; m++) begin
         ahb(1'b1, ADDR_FP_CONTROL_STATUS, 32'(m));
         ex(CVL_D, 64'h4004_0000_0000_0000, 4'h8, rnd[m]);
      end
      ex(op(FN_CONVERT_TO_LONG, FMT_S), 64'hC020_0000, 4'h8, ~64'h2);
      ahb(1'b0, ADDR_FP_CONTROL_STATUS, 32'h0000_1007);
      ahb(1'b1, ADDR_FP_CONTROL_STATUS, 32'h0);
      ex(CVL_D, PINF, 4'h8, LONG_MAX);
      ahb(1'b1, ADDR_FP_CONTROL_STATUS, 32'h0004_0000);
      ex(CVL_D, 64'h7FF8_0000_0000_0000, 4'h8, 64'h0);
      ex(CVL_D, 64'hFFF0_0000_0000_0000, 4'h8, LONG_MIN);
      ex(CVL_D, 64'h43F0_0000_0000_0000, 4'h8, LONG_MAX);
      ahb(1'b0, ADDR_FP_CONTROL_STATUS, 32'h0005_0040);
      ahb(1'b1, ADDR_FP_CONTROL_STATUS, 32'h0000_0800);
      ex(CVL_D, PINF, 4'h1, 64'h0);
      ahb(1'b0, ADDR_ISTAT, 32'h3);
      chk({63'h0, irq}, 64'h0);
      ahb(1'b1, ADDR_IMASK, 32'h2);
      repeat (2) @(posedge clk);
      chk({63'h0, irq}, 64'h1);
      ahb(1'b1, ADDR_ISTAT, 32'hF);
      repeat (2) @(posedge clk);
      chk({63'h0, irq}, 64'h0);
      ahb(1'b0, ADDR_ISTAT, 32'h0);
      ex(op(FN_CVT_PS, FMT_S, 5'h05), PA, 4'h8,
         {PA[31:0], PB[31:0]}, PB);
      ex(op(FN_CVT_SPL, FMT_PS), PA, 4'h8, {32'h0, PA[31:0]});
      ex(op(FN_CONVERT_TO_SINGLE, FMT_PS), PA, 4'h8, {32'h0, PA[63:32]});
      ahb(1'b0, ADDR_FP_CONTROL_STATUS, 32'h0001_0840);
      ex(op(FN_CONVERT_TO_SINGLE, FMT_W), 64'h1, 4'h8, 64'h3F80_0000);
      ex(op(FN_CONVERT_TO_SINGLE, FMT_L), 64'h3, 4'h8, 64'h4040_0000);
      ex(op(FN_CONVERT_TO_SINGLE, FMT_D), 64'h3FF0_0000_0000_0000, 4'h8, 64'h3F80_0000);
      ex(CVL_D, 64'h0, 4'h4, 64'h0, 64'h0, 1'b0);
      ex(op(FN_CONVERT_TO_LONG, FMT_D, 5'h01), 64'h0, 4'h2, 64'h0);
      ex(CVL_D, 64'h0, 4'h1, 64'h0, 64'h0, 1'b1, 1'b0);
      end_of_test();
   end
endmodule : fp_format_conversion_unit_tb_top

bind fp_format_conversion_unit fpcvt_checker i_fpcvt_checker (
   .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
   .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I),
   .FS_VALUE_I(FS_VALUE_I), .FT_VALUE_I(FT_VALUE_I),
   .FPU_USABLE_I(FPU_USABLE_I), .FR_MODE_I(FR_MODE_I), .DONE_O(DONE_O),
   .WRITE_O(WRITE_O), .RESULT_O(RESULT_O), .EXC_FP_O(EXC_FP_O),
   .EXC_COP_UNUSABLE_O(EXC_COP_UNUSABLE_O), .EXC_RESERVED_O(EXC_RESERVED_O));

// File: tb/fpcvt_assertions.sv
// Port assertions for the conversion unit
`timescale 1ns/100ps
module fpcvt_checker
   import fpcvt_pkg::*;
(
   // Clock and reset
   input wire logic        SYS_CLK_I,
   input wire logic        SYS_RST_I,
   // Issue
   input wire logic        INSTR_VALID_I,
   input wire logic [31:0] INSTR_I,
   input wire logic [63:0] FS_VALUE_I,
   input wire logic [63:0] FT_VALUE_I,
   input wire logic        FPU_USABLE_I,
   input wire logic        FR_MODE_I,
   // Completion
   input wire logic        DONE_O,
   input wire logic        WRITE_O,
   input wire logic [63:0] RESULT_O,
   input wire logic        EXC_COP_UNUSABLE_O,
   input wire logic        EXC_RESERVED_O,
   input wire logic        EXC_FP_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   wire logic [5:0] fn  = INSTR_I[5:0];
   wire logic [4:0] fm  = INSTR_I[25:21];
   wire logic       cop = INSTR_VALID_I && INSTR_I[31:26] == OP_FP_COPROCESSOR_OPCODE;
   wire logic       go  = cop && FPU_USABLE_I;
   wire logic       zm  = INSTR_I[20:16] == 5'h00;
   wire logic       lng = go && fn == FN_CONVERT_TO_LONG && zm &&
                          (fm == FMT_S || fm == FMT_D);
   // Completed move with a write
   sequence s_moved;
      DONE_O ##0 WRITE_O;
   endsequence
   a_done_cause: assert property (DONE_O |-> $past(INSTR_VALID_I))
      else $error("done without issue");
   a_long_done: assert property (lng && FR_MODE_I |=> DONE_O ##0
      (WRITE_O ^ EXC_FP_O)) else $error("long conversion not completed");
   a_trap_nowrite: assert property (EXC_FP_O |-> DONE_O && !WRITE_O)
      else $error("trap with write");
   a_long_unimpl: assert property (lng && !FR_MODE_I |=>
      EXC_FP_O && !WRITE_O) else $error("narrow mode long converted");
   a_pack_halves: assert property (go && fn == FN_CVT_PS && fm == FMT_S
      |=> s_moved ##0 RESULT_O == {$past(FS_VALUE_I[31:0]),
      $past(FT_VALUE_I[31:0])}) else $error("pack result wrong");
   a_low_half: assert property (go && fn == FN_CVT_SPL && fm == FMT_PS
      && zm |=> s_moved ##0 RESULT_O == {32'h0, $past(FS_VALUE_I[31:0])})
      else $error("low half wrong");
   a_high_half: assert property (go && fn == FN_CONVERT_TO_SINGLE && fm == FMT_PS
      && zm |=> s_moved ##0 RESULT_O == {32'h0, $past(FS_VALUE_I[63:32])})
      else $error("high half wrong");
   a_no_unit: assert property (cop && !FPU_USABLE_I && fn == FN_CONVERT_TO_LONG
      |=> EXC_COP_UNUSABLE_O && !WRITE_O) else $error("unusable missed");
   a_bad_format: assert property (go && fn == FN_CONVERT_TO_LONG && !zm |=>
      EXC_RESERVED_O && !WRITE_O) else $error("reserved missed");
endmodule : fpcvt_checker

// File: tb/pipe_model.sv
// Pipeline stand-in issuing conversion instructions
`timescale 1ns/100ps
module pipe_model (
   // Clock
   input  wire logic        clk_i,
   // Issue
   output logic             valid_o,
   output logic      [31:0] instr_o,
   output logic      [63:0] src_a_o,
   output logic      [63:0] src_b_o,
   output logic             usable_o,
   output logic             wide_o
);
   initial begin
      valid_o  = 1'b0;
      instr_o  = 32'h0;
      src_a_o  = 64'h0;
      src_b_o  = 64'h0;
      usable_o = 1'b1;
      wide_o   = 1'b1;
   end
   task automatic issue(input logic [31:0] i, input logic [63:0] a, b,
                        input logic u, w);
      valid_o  <= 1'b1;
      instr_o  <= i;
      src_a_o  <= a;
      src_b_o  <= b;
      usable_o <= u;
      wide_o   <= w;
      @(posedge clk_i);
      // Released lines stop showing the last operands
      valid_o  <= 1'b0;
      instr_o  <= ~i;
      src_a_o  <= ~a;
      src_b_o  <= ~b;
   endtask : issue
endmodule : pipe_model
